// [hdl/ief_event_flag.sv]
// Contract
// - direction 1 means master reads from us
// - direction 0 means master writes to us
// - pending flag holds until software writes one
// - fast ack off: flag after ack bit
// - receive mode drives ack per ack select
// - fast ack on: flag after eight bits
// - any address match sets pending flag
// - arbitration loss sets pending flag
// - smbus timeouts set flag, except high ones
// - start/stop sets flag only when enabled
// - clear start/stop flags before pending flag
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "ief_params.svh"

module ief_event_flag (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              ce,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic      [31:0]       hrdata,
    // i2c pins
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    // events from shifter, comparators and timeout counters
    input  wire logic              byte_bits_done,
    input  wire logic              byte_ack_done,
    input  wire logic              ack_slot,
    input  wire logic [4:0]        addr_match,
    input  wire logic              addr_rw,
    input  wire logic              arb_lost,
    input  wire ief_pkg::ief_tmo_t timeout,
    // status and interrupts
    output logic                   slave_direction,
    output logic                   pending_irq,
    output logic                   irq
);

    // ==========================================================
    // register helpers
    function automatic logic wr_hit(input ief_pkg::ief_req_t r, input logic [11:0] ofs);
        wr_hit = r.valid & r.write & (r.addr == ofs);
    endfunction

    function automatic logic rd_hit(input logic [11:0] a, input logic [11:0] ofs);
        rd_hit = (a == ofs);
    endfunction

    // ==========================================================
    // state
    ief_pkg::ief_req_t  req_q;
    ief_pkg::ief_ctrl_t ctrl_q;
    ief_pkg::ief_evt_t  evt_q;
    ief_pkg::ief_evt_t  mask_q;
    logic               pend_q;
    logic               dir_q;
    logic               stop_detected_flag_q;
    logic               start_detected_flag_q;

    // ==========================================================
    // link side: pins sampled on hclk
    logic [1:0] pins_s;
    logic       start_pulse;
    logic       stop_pulse;

    ief_sync #(
        .W (2)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .din     ({scl_in, sda_in}),
        .dout    (pins_s)
    );

    ief_bus_cond u_cond (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .ce          (ce),
        .scl_s       (pins_s[1]),
        .sda_s       (pins_s[0]),
        .start_pulse (start_pulse),
        .stop_pulse  (stop_pulse)
    );

    // ==========================================================
    // ahb address phase capture
    wire addr_phase = hsel & htrans[1] & hready;

    ief_pkg::ief_req_t req_d;
    assign req_d.addr  = haddr[11:0];
    assign req_d.write = hwrite;
    assign req_d.valid = addr_phase;

    // writes land in the data phase, when hwdata is valid
    wire wr_ctrl   = wr_hit(req_q, `IEF_OFS_CTRL);
    wire wr_status = wr_hit(req_q, `IEF_OFS_STATUS);
    wire wr_evt    = wr_hit(req_q, `IEF_OFS_EVT_STAT);
    wire wr_mask   = wr_hit(req_q, `IEF_OFS_EVT_MASK);

    // ==========================================================
    // event sources
    wire any_match = |addr_match;
    wire byte_evt  = ctrl_q.fast_ack_mode ? byte_bits_done : byte_ack_done;
    wire tmo_evt   = ctrl_q.smbus_mode & (timeout.clk_low | timeout.cumulative);
    wire ss_pulse  = ctrl_q.stop_start_irq_enable & (start_pulse | stop_pulse);
    // a still-set stop/start flag keeps re-raising pending until cleared first
    wire ss_level  = ctrl_q.stop_start_irq_enable & (stop_detected_flag_q | start_detected_flag_q);

    wire pend_set  = byte_evt | any_match | arb_lost | tmo_evt | ss_pulse | ss_level;
    // only a written one clears; set term wins a same-cycle clear
    wire pend_clr  = wr_status & hwdata[`IEF_ST_PEND];
    wire pend_d    = pend_set | (pend_q & ~pend_clr);

    wire stop_detected_flag_d   = stop_pulse | (stop_detected_flag_q & ~(wr_status & hwdata[`IEF_ST_STOP_DETECTED_FLAG]));
    wire start_detected_flag_d  = start_pulse | (start_detected_flag_q & ~(wr_status & hwdata[`IEF_ST_START_DETECTED_FLAG]));

    // direction follows the r/w bit of the matching address
    wire dir_d     = any_match ? addr_rw : dir_q;

    // ==========================================================
    // interrupt status and mask
    ief_pkg::ief_evt_t evt_now;
    assign evt_now.byte_done = byte_evt;
    assign evt_now.addr      = any_match;
    assign evt_now.arb       = arb_lost;
    assign evt_now.tmo       = tmo_evt;
    assign evt_now.stop      = stop_pulse;
    assign evt_now.start     = start_pulse;

    wire [`IEF_EV_W-1:0] evt_clr = wr_evt ? hwdata[`IEF_EV_W-1:0] : '0;
    wire [`IEF_EV_W-1:0] evt_d   = evt_now | (evt_q & ~evt_clr);
    wire [`IEF_EV_W-1:0] mask_d  = wr_mask ? hwdata[`IEF_EV_W-1:0] : mask_q;
    wire                 irq_d   = |(evt_d & mask_d);

    // ==========================================================
    // ack drive: low on sda during ack slot when ack chosen
    wire ack_drive = ack_slot & ctrl_q.rx_mode & ~ctrl_q.ack_value_select;

    // ==========================================================
    // read mux, decoded in the address phase
    ief_pkg::ief_req_t rd_req;
    assign rd_req = req_d;

    wire [`IEF_ST_W-1:0] status_v = {start_detected_flag_q, stop_detected_flag_q, dir_q, pend_q};

    wire [31:0] rd_mux =
        rd_hit(rd_req.addr, `IEF_OFS_CTRL)     ? {27'h000_0000, ctrl_q}   :
        rd_hit(rd_req.addr, `IEF_OFS_STATUS)   ? {28'h000_0000, status_v} :
        rd_hit(rd_req.addr, `IEF_OFS_EVT_STAT) ? {26'h000_0000, evt_q}    :
        rd_hit(rd_req.addr, `IEF_OFS_EVT_MASK) ? {26'h000_0000, mask_q}   :
                                                 `IEF_RST_DATA;
    wire rd_take = addr_phase & ~hwrite;

    // ==========================================================
    // bus registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q     <= '0;
            hrdata    <= `IEF_RST_DATA;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            req_q     <= req_d;
            hrdata    <= rd_take ? rd_mux : hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ==========================================================
    // control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `IEF_RST_CTRL;
        end else if (ce && wr_ctrl) begin
            ctrl_q <= hwdata[`IEF_CTRL_W-1:0];
        end
    end

    // ==========================================================
    // pending flag, direction and condition flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q   <= 1'b0;
            dir_q    <= 1'b0;
            stop_detected_flag_q  <= 1'b0;
            start_detected_flag_q <= 1'b0;
        end else if (ce) begin
            pend_q   <= pend_d;
            dir_q    <= dir_d;
            stop_detected_flag_q  <= stop_detected_flag_d;
            start_detected_flag_q <= start_detected_flag_d;
        end
    end

    // ==========================================================
    // interrupt registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_q  <= '0;
            mask_q <= `IEF_RST_MASK;
            irq    <= 1'b0;
        end else if (ce) begin
            evt_q  <= evt_d;
            mask_q <= mask_d;
            irq    <= irq_d;
        end
    end

    // ==========================================================
    // outputs to pins and core
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sda_out         <= 1'b0;
            sda_oe          <= 1'b0;
            slave_direction <= 1'b0;
            pending_irq     <= 1'b0;
        end else if (ce) begin
            sda_out         <= 1'b0;
            sda_oe          <= ack_drive;
            slave_direction <= dir_d;
            pending_irq     <= pend_d;
        end
    end

    // hsize is not checked: every access is handled as a full word
    wire unused_ok = &{1'b0, hsize, haddr[31:12], timeout.clk_high, timeout.data_high};

endmodule

// [hdl/ief_params.svh]
`ifndef IEF_PARAMS_SVH
`define IEF_PARAMS_SVH

// ==========================================================
// register byte offsets (haddr[11:0])
`define IEF_OFS_CTRL        12'h000
`define IEF_OFS_STATUS      12'h004
`define IEF_OFS_EVT_STAT    12'h008
`define IEF_OFS_EVT_MASK    12'h00C

// ==========================================================
// control register fields
`define IEF_CTRL_FAST_ACK_MODE       0
`define IEF_CTRL_ACKSEL     1
`define IEF_CTRL_STOP_START_IRQ_ENABLE       2
`define IEF_CTRL_SMBUS      3
`define IEF_CTRL_RXMODE     4
`define IEF_CTRL_W          5

// ==========================================================
// status register fields
`define IEF_ST_PEND         0
`define IEF_ST_DIR          1
`define IEF_ST_STOP_DETECTED_FLAG        2
`define IEF_ST_START_DETECTED_FLAG       3
`define IEF_ST_W            4

// ==========================================================
// event status / mask fields
`define IEF_EV_BYTE         0
`define IEF_EV_ADDR         1
`define IEF_EV_ARB          2
`define IEF_EV_TMO          3
`define IEF_EV_STOP         4
`define IEF_EV_START        5
`define IEF_EV_W            6

// ==========================================================
// reset values
`define IEF_RST_CTRL        5'h00
`define IEF_RST_MASK        6'h00
`define IEF_RST_DATA        32'h0000_0000

`endif

// [hdl/ief_pkg.sv]
package ief_pkg;

    // ==========================================================
    // control fields, msb first so bit 0 is fast_ack_mode
    typedef struct packed {
        logic rx_mode;
        logic smbus_mode;
        logic stop_start_irq_enable;
        logic ack_value_select;
        logic fast_ack_mode;
    } ief_ctrl_t;

    // ==========================================================
    // timeout strobes from the timeout counters
    typedef struct packed {
        logic data_high;
        logic clk_high;
        logic cumulative;
        logic clk_low;
    } ief_tmo_t;

    // ==========================================================
    // event vector, same layout as event status and mask
    typedef struct packed {
        logic start;
        logic stop;
        logic tmo;
        logic arb;
        logic addr;
        logic byte_done;
    } ief_evt_t;

    // ==========================================================
    // captured ahb address phase
    typedef struct packed {
        logic [11:0] addr;
        logic        write;
        logic        valid;
    } ief_req_t;

endpackage

// [hdl/ief_sync.sv]
`timescale 1ns/100ps

// ==========================================================
// two-flop synchroniser for pin levels
module ief_sync #(
    parameter int W = 2
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '1;
            dout   <= '1;
        end else if (ce) begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// [hdl/ief_bus_cond.sv]
`timescale 1ns/100ps

// ==========================================================
// start/stop condition detector on synchronised scl/sda
module ief_bus_cond (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    input  wire logic scl_s,
    input  wire logic sda_s,
    output logic      start_pulse,
    output logic      stop_pulse
);
    logic scl_prev_q;
    logic sda_prev_q;
    wire  scl_held = scl_s & scl_prev_q;

    // sda moving while scl stays high marks a condition
    assign start_pulse = ce & scl_held & sda_prev_q & ~sda_s;
    assign stop_pulse  = ce & scl_held & ~sda_prev_q & sda_s;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else if (ce) begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end
endmodule

// [bench/ief_event_flag_checker.sv]
`timescale 1ns/100ps
`include "ief_params.svh"

module ief_event_flag_checker (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              ce,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic              sda_oe,
    input wire logic              byte_bits_done,
    input wire logic              byte_ack_done,
    input wire logic              ack_slot,
    input wire logic [4:0]        addr_match,
    input wire logic              addr_rw,
    input wire logic              arb_lost,
    input wire ief_pkg::ief_tmo_t timeout,
    input wire logic              slave_direction,
    input wire logic              pending_irq
);
    // ==========================================================
    // shadow of control and status writes
    // control shadow lets byte and ack checks know the mode
    logic       wst_q;
    logic       wct_q;
    logic [4:0] ctl_q;
    wire  logic take_w = ce & hsel & htrans[1] & hready & hwrite;
    // ack drive the design should register this cycle
    wire  logic ack_want = ack_slot & ctl_q[4] & ~ctl_q[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wst_q <= 1'b0;
            wct_q <= 1'b0;
            ctl_q <= 5'h00;
        end else if (ce) begin
            wst_q <= take_w & (haddr[11:0] == `IEF_OFS_STATUS);
            wct_q <= take_w & (haddr[11:0] == `IEF_OFS_CTRL);
            if (wct_q) ctl_q <= hwdata[4:0];
        end
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_arb; ce && arb_lost |=> pending_irq; endproperty
    property p_addr; ce && addr_match != 5'h00 |=> pending_irq && slave_direction == $past(addr_rw); endproperty
    property p_dir0; ce && addr_match != 5'h00 && !addr_rw |=> !slave_direction; endproperty
    property p_hold; pending_irq && !(wst_q && hwdata[0]) |=> pending_irq; endproperty
    property p_setwin; ce && arb_lost && wst_q && hwdata[0] |=> pending_irq; endproperty
    property p_fast; ce && byte_bits_done && ctl_q[0] |=> pending_irq; endproperty
    property p_slow; ce && byte_ack_done && !ctl_q[0] |=> pending_irq; endproperty
    property p_ack; ce |=> sda_oe == $past(ack_want); endproperty
    property p_tmo; ce && ctl_q[3] && (timeout.clk_low || timeout.cumulative) |=> pending_irq; endproperty
    property p_okay; hreadyout && !hresp; endproperty
    a_arb: assert property (p_arb) else $error("arbitration loss left flag clear");
    a_addr: assert property (p_addr) else $error("address match flag or direction wrong");
    a_dir0: assert property (p_dir0) else $error("direction not zero on write call");
    a_hold: assert property (p_hold) else $error("pending flag dropped without clear");
    a_setwin: assert property (p_setwin) else $error("clear beat a set event");
    a_fast: assert property (p_fast) else $error("eight bit event left flag clear");
    a_slow: assert property (p_slow) else $error("ack bit event left flag clear");
    a_ack: assert property (p_ack) else $error("ack drive wrong");
    a_tmo: assert property (p_tmo) else $error("smbus timeout left flag clear");
    a_okay: assert property (p_okay) else $error("bus answer not ready okay");
    c_clr: cover property (wst_q && hwdata[0] && pending_irq);
    c_arb: cover property (ce && arb_lost);
    c_ack: cover property (sda_oe);
endmodule

// [bench/ief_bus_partner.sv]
`timescale 1ns/100ps

module ief_bus_partner (
    input  wire logic sda_oe,
    input  wire logic sda_out,
    output logic      scl,
    output wire logic sda
);
    logic sda_drv;
    // open drain with pull-up: a low from either side wins
    assign sda = sda_drv & ~(sda_oe & ~sda_out);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // scl stands still between frames; half link period is 160 ns
    task automatic start_cond();
        #7;
        sda_drv = 1'b0;
        #160;
        scl = 1'b0;
    endtask
    task automatic stop_cond();
        #160;
        scl = 1'b1;
        #160;
        sda_drv = 1'b1;
    endtask
endmodule

// [bench/test_ief_event_flag.sv]
`timescale 1ns/100ps
`include "ief_params.svh"

module test_ief_event_flag;
    logic             hclk, hresetn, hsel, hwrite, ack_slot, addr_rw, dir_e, rb;
    logic [1:0]       htrans;
    logic [11:0]      evs;
    logic [31:0]      haddr, hwdata, rd_val, sv;
    wire logic        hready, hresp, scl, sda, sda_out, sda_oe, slave_direction, pending_irq, irq;
    wire logic [31:0] hrdata;
    int               err_total, n_compared, seed, cyc;
    int               ti[15] = '{0, 1, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 8};
    logic [14:0]      te = 15'h0ff6;
    logic [31:0]      exp_q[$];
    event             got;

    ief_event_flag dut (
        .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .byte_bits_done(evs[0]), .byte_ack_done(evs[1]), .ack_slot(ack_slot), .addr_match(evs[6:2]),
        .addr_rw(addr_rw), .arb_lost(evs[7]), .timeout(ief_pkg::ief_tmo_t'(evs[11:8])),
        .slave_direction(slave_direction), .pending_irq(pending_irq), .irq(irq));
    ief_bus_partner bus (.sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // ahb-lite single word transfer, holds each phase until hready
    task automatic bus_xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0_0000, a};
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd_val = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus_xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus_xfer(a, 1'b0, 32'h0000_0000);
        -> got;
    endtask
    // output level one step after the edge so the edge's updates land
    // s: 0 sda_oe, 1 irq, 2 pending_irq, 3 slave_direction, 4 sda_out
    task automatic pin(input logic e, input int s);
        exp_q.push_back({31'h0, e});
        #1;
        rd_val = {31'h0, (s == 0) ? sda_oe : (s == 1) ? irq : (s == 2) ? pending_irq :
                         (s == 3) ? slave_direction : sda_out};
        -> got;
        @(posedge hclk);
    endtask
    task automatic pulse(input int k);
        evs[k] <= 1'b1;
        @(posedge hclk);
        evs <= 12'h000;
        @(posedge hclk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    initial forever begin
        @(got);
        chk(rd_val, exp_q.pop_front());
    end

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        {hsel, hwrite, ack_slot, addr_rw, dir_e} = 5'h00;
        htrans = 2'h0;
        evs = 12'h000;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        seed = 23609;
        hresetn = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 5; i++) rd(12'(i * 4), 32'h0000_0000);
        sv = $random(seed);
        wr(`IEF_OFS_CTRL, sv);
        rd(`IEF_OFS_CTRL, sv & 32'h0000_001f);
        wr(`IEF_OFS_CTRL, 32'h0000_0000);
        $display("test registers done");
        for (int i = 0; i < 15; i++) begin
            wr(`IEF_OFS_CTRL, (i == 2 || i == 3) ? 32'h0000_0001 : (i >= 10 && i < 14) ? 32'h0000_0008 : 0);
            rb = 1'($random(seed));
            addr_rw <= rb;
            if (ti[i] >= 2 && ti[i] <= 6) dir_e = rb;
            pulse(ti[i]);
            pin(te[i], 2);
            pin(dir_e, 3);
            rd(`IEF_OFS_STATUS, {30'h0, dir_e, te[i]});
            wr(`IEF_OFS_STATUS, 32'h0000_0001);
            wr(`IEF_OFS_EVT_STAT, 32'h0000_003f);
        end
        $display("test event sources done");
        sv = {30'h0, dir_e, 1'b0};
        pulse(7);
        wr(`IEF_OFS_STATUS, 32'h0000_0000);
        rd(`IEF_OFS_STATUS, sv | 1);
        fork
            wr(`IEF_OFS_STATUS, 32'h0000_0001);
            begin
                @(posedge hclk);
                pulse(7);
            end
        join
        rd(`IEF_OFS_STATUS, sv | 1);
        wr(`IEF_OFS_STATUS, 32'h0000_0001);
        rd(`IEF_OFS_STATUS, sv);
        $display("test clear done");
        wr(`IEF_OFS_EVT_MASK, 32'h0000_0004);
        pin(1'b1, 1'b1);
        wr(`IEF_OFS_EVT_MASK, 32'h0000_0000);
        pin(1'b0, 1'b1);
        wr(`IEF_OFS_EVT_MASK, 32'h0000_0004);
        wr(`IEF_OFS_EVT_STAT, 32'h0000_0004);
        pin(1'b0, 1'b1);
        $display("test interrupt done");
        wr(`IEF_OFS_CTRL, 32'h0000_0004);
        bus.start_cond();
        repeat (8) @(posedge hclk);
        rd(`IEF_OFS_STATUS, sv | 9);
        wr(`IEF_OFS_STATUS, 32'h0000_0001);
        repeat (2) @(posedge hclk);
        rd(`IEF_OFS_STATUS, sv | 9);
        wr(`IEF_OFS_STATUS, 32'h0000_0008);
        wr(`IEF_OFS_STATUS, 32'h0000_0001);
        repeat (2) @(posedge hclk);
        rd(`IEF_OFS_STATUS, sv);
        wr(`IEF_OFS_CTRL, 32'h0000_0000);
        bus.stop_cond();
        repeat (8) @(posedge hclk);
        rd(`IEF_OFS_STATUS, sv | 4);
        $display("test start stop done");
        wr(`IEF_OFS_CTRL, 32'h0000_0010);
        ack_slot <= 1'b1;
        @(posedge hclk);
        pin(1'b1, 1'b0);
        wr(`IEF_OFS_CTRL, 32'h0000_0012);
        @(posedge hclk);
        pin(1'b0, 1'b0);
        pin(1'b0, 4);
        ack_slot <= 1'b0;
        $display("test ack drive done");
        @(posedge hclk);
        test_done();
    end
endmodule

bind ief_event_flag ief_event_flag_checker u_chk (.*);
